// *** include/iwd_pkg.sv ***
// Package: constants, field layouts and enumerations of the instruction word decoder
package iwd_pkg;

   // ----------------------------------------------------------------
   // Word and field widths
   // ----------------------------------------------------------------
   localparam int unsigned WORD_W        = 16;
   localparam int unsigned FILE_W        = 8;
   localparam int unsigned FULL_FILE_W   = 12;
   localparam int unsigned BIT_W         = 3;
   localparam int unsigned LIT8_W        = 8;
   localparam int unsigned LIT12_W       = 12;
   localparam int unsigned LIT20_W       = 20;
   localparam int unsigned BRA_LONG_W    = 11;
   localparam int unsigned BRA_SHORT_W   = 8;
   localparam int unsigned CYC_W         = 2;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned POS_FILE      = 0;
   localparam int unsigned POS_ACCESS    = 8;
   localparam int unsigned POS_DEST      = 9;
   localparam int unsigned POS_BIT       = 9;
   localparam int unsigned POS_FAST      = 0;
   localparam int unsigned POS_TBL_MODE  = 0;
   localparam int unsigned POS_FSR_SEL   = 4;

   // ----------------------------------------------------------------
   // Second-word marker and timing
   // ----------------------------------------------------------------
   localparam logic [3:0] SECOND_WORD_TAG = 4'hF;
   localparam int unsigned OSC_PER_CYCLE  = 4;
   localparam logic [CYC_W-1:0] CYC_ONE   = 2'h1;
   localparam logic [CYC_W-1:0] CYC_TWO   = 2'h2;
   localparam logic [CYC_W-1:0] CYC_THREE = 2'h3;

   // ----------------------------------------------------------------
   // Opcode patterns (upper bits of the first word)
   // ----------------------------------------------------------------
   localparam logic [3:0] OP4_MOVE_FF     = 4'hC;
   localparam logic [3:0] OP4_BIT_LO      = 4'h7;
   localparam logic [3:0] OP4_BIT_HI      = 4'hB;
   localparam logic [3:0] OP4_BRANCH_REL  = 4'hD;
   localparam logic [3:0] OP4_CONTROL     = 4'hE;
   localparam logic [3:0] OP4_LITERAL     = 4'h0;
   localparam logic [7:0] OP8_CALL_LO     = 8'hEC;
   localparam logic [7:0] OP8_CALL_HI     = 8'hED;
   localparam logic [7:0] OP8_GOTO        = 8'hEF;
   localparam logic [7:0] OP8_LOAD_FSR    = 8'hEE;
   localparam logic [7:0] OP8_COND_BRA_LO = 8'hE0;
   localparam logic [7:0] OP8_COND_BRA_HI = 8'hE7;
   localparam logic [7:0] OP8_LIT_LO      = 8'h08;
   localparam logic [7:0] OP8_LIT_HI      = 8'h0F;
   localparam logic [7:0] OP8_LIT_BANK    = 8'h01;
   localparam logic [7:0] OP8_LIT_RETURN  = 8'h0C;
   localparam logic [11:0] OP12_TBL       = 12'h000;
   localparam logic [15:0] WORD_RETURN_LO = 16'h0012;
   localparam logic [15:0] WORD_RETFIE_LO = 16'h0010;
   localparam logic [15:0] WORD_TBL_LO    = 16'h0008;
   localparam logic [15:0] WORD_TBL_HI    = 16'h000F;

   // ----------------------------------------------------------------
   // Enumerations
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      IWD_CLS_BYTE    = 2'h0,
      IWD_CLS_BIT     = 2'h1,
      IWD_CLS_LITERAL = 2'h2,
      IWD_CLS_CONTROL = 2'h3
   } iwd_class_e;

   typedef enum logic [1:0] {
      IWD_TBL_KEEP     = 2'h0,
      IWD_TBL_POST_INC = 2'h1,
      IWD_TBL_POST_DEC = 2'h2,
      IWD_TBL_PRE_INC  = 2'h3
   } iwd_tbl_mode_e;

   typedef enum logic [1:0] {
      IWD_DW_NONE  = 2'h0,
      IWD_DW_MOVE  = 2'h1,
      IWD_DW_JUMP  = 2'h2,
      IWD_DW_LFSR  = 2'h3
   } iwd_dw_kind_e;

   // Sequencer states, Gray order along FIRST -> SECOND -> FILL
   typedef enum logic [1:0] {
      IWD_ST_FIRST  = 2'b00,
      IWD_ST_SECOND = 2'b01,
      IWD_ST_FILL   = 2'b11
   } iwd_state_e;

endpackage : iwd_pkg

// *** include/iwd_phase_if.sv ***
// Interface: quarter-cycle phase signals shared between the phase counter and the decoder
`timescale 1ns/100ps
`default_nettype none
interface iwd_phase_if;
   logic cycle_start;
   logic cycle_end;
   logic [1:0] phase;
   modport gen (output cycle_start, output cycle_end, output phase);
   modport use_p (input cycle_start, input cycle_end, input phase);
endinterface : iwd_phase_if
`default_nettype wire

// *** design/iwd_phase_gen.sv ***
// Module: divides the oscillator clock into four-period instruction cycles
`timescale 1ns/100ps
`default_nettype none
module iwd_phase_gen
   import iwd_pkg::*;
(
   input  wire logic   i_sys_clk,
   input  wire logic   i_arst_n,
   input  wire logic   i_clk_en,
   iwd_phase_if.gen    ph
);
   logic [1:0] phase_r;

   // Four oscillator periods per instruction cycle
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         phase_r <= 2'h0;
      end else if (i_clk_en) begin
         phase_r <= 2'(phase_r + 2'h1);
      end
   end

   assign ph.phase       = phase_r;
   assign ph.cycle_start = (phase_r == 2'h0);
   assign ph.cycle_end   = (phase_r == 2'(OSC_PER_CYCLE - 1));
endmodule : iwd_phase_gen
`default_nettype wire

// *** design/iwd_decoder.sv ***
// Module: instruction word decoder with operand fields and cycle cost
// Notes on behaviour
// - Instructions are one 16-bit word, except move, call, goto and pointer load, which span two words.
// - Second words carry ones in the top four bits; alone they act as NOP.
// - Single-word: one cycle; two when test true or PC changes, extra is NOP.
// - Double-word instructions take two instruction cycles.
// - One instruction cycle is four oscillator periods.
// - A two-word branch costs two instruction cycles; no instruction costs three.
// - Destination bit zero writes working register, one writes the file register.
// - Access bit zero selects access RAM; one uses the bank select register.
// - Bit instructions carry a three-bit index choosing bit 0 to 7.
// - File operations carry an 8-bit address with bank or access selection.
// - Byte-to-byte move carries 12-bit source and target addresses.
// - Literals come out as 8, 12 or 20 bits depending on instruction.
// - Table instructions carry a four-way table pointer update mode.
// - Relative branches use signed offsets; call and goto use absolute targets.
// - Instructions classed byte, bit, literal or control.
// - Fast bit set requests shadow save or restore; clear requests none.
`timescale 1ns/100ps
`default_nettype none
module iwd_decoder
   import iwd_pkg::*;
(
   input  wire logic                         i_sys_clk,
   input  wire logic                         i_arst_n,
   input  wire logic                         i_clk_en,
   input  wire logic                         i_word_valid,
   input  wire logic [iwd_pkg::WORD_W-1:0]   i_word,
   input  wire logic                         i_cond_true,
   output logic                              o_word_ready,
   output logic                              o_cycle_start,
   output logic                              o_dec_valid,
   output iwd_pkg::iwd_class_e               o_class,
   output logic                              o_double_word,
   output logic                              o_exec_nop,
   output logic                              o_dest_is_file,
   output logic                              o_use_bank_select,
   output logic [iwd_pkg::FILE_W-1:0]        o_file_addr,
   output logic [iwd_pkg::BIT_W-1:0]         o_bit_index,
   output logic [iwd_pkg::FULL_FILE_W-1:0]   o_source_file_address,
   output logic [iwd_pkg::FULL_FILE_W-1:0]   o_target_file_address,
   output logic [iwd_pkg::LIT8_W-1:0]        o_literal8,
   output logic [iwd_pkg::LIT12_W-1:0]       o_literal12,
   output logic [iwd_pkg::LIT20_W-1:0]       o_literal20,
   output logic [iwd_pkg::LIT20_W-1:0]       o_branch_offset,
   output logic                              o_branch_rel,
   output logic                              o_branch_cond,
   output logic                              o_fast_mode,
   output iwd_pkg::iwd_tbl_mode_e            o_table_pointer_update_mode,
   output logic [iwd_pkg::CYC_W-1:0]         o_cycle_cost
);
   import iwd_pkg::*;

   // ----------------------------------------------------------------
   // Instruction cycle timing
   // ----------------------------------------------------------------
   iwd_phase_if ph ();

   iwd_phase_gen u_phase (
      .i_sys_clk (i_sys_clk),
      .i_arst_n  (i_arst_n),
      .i_clk_en  (i_clk_en),
      .ph        (ph.gen)
   );

   // ----------------------------------------------------------------
   // First-word classification
   // ----------------------------------------------------------------
   logic [3:0]   op4;
   logic [7:0]   op8;
   iwd_class_e   cls;
   iwd_dw_kind_e dw_kind;
   logic         is_second_word;
   logic         pc_change;
   logic         is_cond;
   logic         is_table;
   logic         is_return;
   logic         is_rel_long;
   logic         is_rel_cond;

   assign op4 = i_word[15:12];
   assign op8 = i_word[15:8];
   // A lone second word cannot start a valid instruction
   assign is_second_word = (op4 == SECOND_WORD_TAG);
   assign is_table  = (i_word >= WORD_TBL_LO) && (i_word <= WORD_TBL_HI);
   assign is_return = (i_word[15:1] == WORD_RETURN_LO[15:1])
                   || (i_word[15:1] == WORD_RETFIE_LO[15:1]);
   assign is_rel_long = (op4 == OP4_BRANCH_REL);
   assign is_rel_cond = (op8 >= OP8_COND_BRA_LO) && (op8 <= OP8_COND_BRA_HI);

   always_comb begin
      cls       = IWD_CLS_BYTE;
      dw_kind   = IWD_DW_NONE;
      pc_change = 1'b0;
      is_cond   = 1'b0;
      // Opcode upper bits select the class
      if (op4 == OP4_MOVE_FF) begin
         cls     = IWD_CLS_CONTROL;
         dw_kind = IWD_DW_MOVE;
      end else if (op8 == OP8_CALL_LO || op8 == OP8_CALL_HI || op8 == OP8_GOTO) begin
         cls       = IWD_CLS_CONTROL;
         dw_kind   = IWD_DW_JUMP;
         pc_change = 1'b1;
      end else if (op8 == OP8_LOAD_FSR) begin
         cls     = IWD_CLS_LITERAL;
         dw_kind = IWD_DW_LFSR;
      end else if (is_second_word) begin
         cls = IWD_CLS_CONTROL;
      end else if (is_rel_long) begin
         cls       = IWD_CLS_CONTROL;
         pc_change = 1'b1;
      end else if (is_rel_cond) begin
         cls     = IWD_CLS_CONTROL;
         is_cond = 1'b1;
      end else if (op4 >= OP4_BIT_LO && op4 <= OP4_BIT_HI) begin
         cls     = IWD_CLS_BIT;
         is_cond = (op4 == 4'hA) || (op4 == 4'hB);
      end else if ((op8 >= OP8_LIT_LO && op8 <= OP8_LIT_HI) || op8 == OP8_LIT_BANK) begin
         cls       = IWD_CLS_LITERAL;
         // Return with a literal reloads the program counter
         pc_change = (op8 == OP8_LIT_RETURN);
      end else if (op4 == OP4_LITERAL) begin
         cls       = IWD_CLS_CONTROL;
         pc_change = is_return;
      end else begin
         cls     = IWD_CLS_BYTE;
         is_cond = (op4 == 4'h2 && i_word[11:10] == 2'h3)
                || (op4 == 4'h3 && i_word[11:10] == 2'h3)
                || (op4 == 4'h4 && i_word[11:10] != 2'h0)
                || (op4 == 4'h6 && i_word[11:9] <= 3'h2);
      end
   end

   // ----------------------------------------------------------------
   // Sequencer: first word, second word, filler cycles
   // ----------------------------------------------------------------
   iwd_state_e   state_r;
   iwd_dw_kind_e kind_r;
   logic [1:0]   fill_r;
   logic         take_word;

   // A word is taken once per instruction cycle, at its last phase
   assign take_word    = i_clk_en && ph.cycle_end && i_word_valid && (state_r != IWD_ST_FILL);
   assign o_word_ready = ph.cycle_end && (state_r != IWD_ST_FILL);
   assign o_cycle_start = ph.cycle_start;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_r <= IWD_ST_FIRST;
         kind_r  <= IWD_DW_NONE;
         fill_r  <= 2'h0;
      end else if (i_clk_en && ph.cycle_end) begin
         unique case (state_r)
            IWD_ST_FIRST: begin
               if (i_word_valid) begin
                  kind_r <= dw_kind;
                  if (dw_kind != IWD_DW_NONE) begin
                     state_r <= IWD_ST_SECOND;
                  end else if (pc_change || (is_cond && i_cond_true)) begin
                     fill_r  <= 2'h1;
                     state_r <= IWD_ST_FILL;
                  end
               end
            end
            IWD_ST_SECOND: begin
               if (i_word_valid) begin
                  state_r <= IWD_ST_FIRST;
               end
            end
            IWD_ST_FILL: begin
               if (fill_r == 2'h1) begin
                  state_r <= IWD_ST_FIRST;
               end
               fill_r <= 2'(fill_r - 2'h1);
            end
            default: begin
               state_r <= IWD_ST_FIRST;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Field registers
   // ----------------------------------------------------------------
   logic take_first;
   logic take_second;
   assign take_first  = take_word && (state_r == IWD_ST_FIRST);
   assign take_second = take_word && (state_r == IWD_ST_SECOND);

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_class                     <= IWD_CLS_CONTROL;
         o_double_word               <= 1'b0;
         o_exec_nop                  <= 1'b1;
         o_dest_is_file              <= 1'b0;
         o_use_bank_select           <= 1'b0;
         o_file_addr                 <= 8'h00;
         o_bit_index                 <= 3'h0;
         o_literal8                  <= 8'h00;
         o_branch_rel                <= 1'b0;
         o_branch_cond               <= 1'b0;
         o_fast_mode                 <= 1'b0;
         o_table_pointer_update_mode <= IWD_TBL_KEEP;
         o_cycle_cost                <= CYC_ONE;
      end else if (take_first) begin
         o_class           <= cls;
         o_double_word     <= (dw_kind != IWD_DW_NONE);
         o_exec_nop        <= is_second_word;
         o_dest_is_file    <= i_word[POS_DEST];
         o_use_bank_select <= i_word[POS_ACCESS];
         o_file_addr       <= i_word[POS_FILE +: FILE_W];
         o_bit_index       <= i_word[POS_BIT +: BIT_W];
         o_literal8        <= i_word[LIT8_W-1:0];
         o_branch_rel      <= is_rel_long || is_rel_cond;
         o_branch_cond     <= is_cond;
         o_fast_mode       <= (is_return || dw_kind == IWD_DW_JUMP)
                              && i_word[POS_FAST];
         o_table_pointer_update_mode <= is_table
            ? iwd_tbl_mode_e'(i_word[POS_TBL_MODE +: 2]) : IWD_TBL_KEEP;
         if (dw_kind != IWD_DW_NONE) begin
            o_cycle_cost <= CYC_TWO;
         end else if (pc_change || (is_cond && i_cond_true)) begin
            o_cycle_cost <= CYC_TWO;
         end else begin
            o_cycle_cost <= CYC_ONE;
         end
      end
   end

   // Skip over a following double word costs no extra cycle; CYC_THREE stays unused
   logic [CYC_W-1:0] unused_cost;
   assign unused_cost = CYC_THREE;

   // Wide fields: first word supplies low part of o_literal20 and high part of o_literal12, second word the rest
   logic [LIT8_W-1:0] lo8_r;
   logic [3:0]        fsr_sel_r;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         lo8_r                 <= 8'h00;
         fsr_sel_r             <= 4'h0;
         o_source_file_address <= 12'h000;
         o_target_file_address <= 12'h000;
         o_literal12           <= 12'h000;
         o_literal20           <= 20'h00000;
         o_branch_offset       <= 20'h00000;
         o_dec_valid           <= 1'b0;
      end else if (i_clk_en) begin
         o_dec_valid <= 1'b0;
         if (take_first) begin
            lo8_r     <= i_word[7:0];
            fsr_sel_r <= i_word[7:4];
            o_dec_valid <= (dw_kind == IWD_DW_NONE);
            if (dw_kind == IWD_DW_MOVE) begin
               o_source_file_address <= i_word[FULL_FILE_W-1:0];
            end
            if (is_rel_long) begin
               o_branch_offset <= {{(LIT20_W-BRA_LONG_W){i_word[BRA_LONG_W-1]}},
                                   i_word[BRA_LONG_W-1:0]};
            end else if (is_rel_cond) begin
               o_branch_offset <= {{(LIT20_W-BRA_SHORT_W){i_word[BRA_SHORT_W-1]}},
                                   i_word[BRA_SHORT_W-1:0]};
            end
         end else if (take_second) begin
            o_dec_valid <= 1'b1;
            unique case (kind_r)
               IWD_DW_MOVE:
                  o_target_file_address <= i_word[FULL_FILE_W-1:0];
               IWD_DW_JUMP:
                  o_literal20 <= {i_word[11:0], lo8_r};
               IWD_DW_LFSR:
                  o_literal12 <= {fsr_sel_r[3:0], i_word[7:0]};
               IWD_DW_NONE: begin
               end
            endcase
         end
      end
   end

endmodule : iwd_decoder
`default_nettype wire

// *** dv/iwd_fetch_model.sv ***
// Fetch-side model: offers queued program words to the decoder
`timescale 1ns/100ps
`default_nettype none
module iwd_fetch_model (
   input  wire logic    i_sys_clk,
   input  wire logic    i_clk_en,
   input  wire logic    i_word_ready,
   input  wire logic    i_stall,
   output logic         o_word_valid = 1'b0,
   output logic [15:0]  o_word = 16'h0000,
   output logic         o_cond_true = 1'b0
);
   logic [16:0] q[$];
   wire         taken = i_clk_en && i_word_ready && o_word_valid;

   task automatic push(input logic [15:0] w, input logic c);
      q.push_back({c, w});
   endtask : push

   // A raised offer holds until taken; stall only delays raising it
   always @(posedge i_sys_clk) begin
      if (taken) void'(q.pop_front());
      if (o_word_valid && !taken) begin
      end else if (q.size() != 0 && !i_stall) begin
         o_word_valid <= 1'b1;
         o_word <= q[0][15:0];
         o_cond_true <= q[0][16];
      end else begin
         // Idle bus shows the inverse, so no stale word can pass as fresh
         o_word_valid <= 1'b0;
         o_word <= ~o_word;
         o_cond_true <= ~o_cond_true;
      end
   end
endmodule : iwd_fetch_model
`default_nettype wire

// *** dv/iwd_decoder_asserts.sv ***
// Checker: port-level properties of the instruction word decoder
`timescale 1ns/100ps
`default_nettype none
module iwd_decoder_asserts
   import iwd_pkg::*;
(
   input wire logic                   i_sys_clk,
   input wire logic                   i_arst_n,
   input wire logic                   i_clk_en,
   input wire logic                   i_word_valid,
   input wire logic [WORD_W-1:0]      i_word,
   input wire logic                   o_word_ready,
   input wire logic                   o_cycle_start,
   input wire logic                   o_dec_valid,
   input wire iwd_class_e             o_class,
   input wire logic                   o_double_word,
   input wire logic                   o_exec_nop,
   input wire logic                   o_dest_is_file,
   input wire logic                   o_use_bank_select,
   input wire logic [FILE_W-1:0]      o_file_addr,
   input wire logic [BIT_W-1:0]       o_bit_index,
   input wire logic                   o_branch_rel,
   input wire logic [CYC_W-1:0]       o_cycle_cost
);
   logic [1:0] ph_r;
   logic       sec_r;
   wire        taken = i_clk_en && o_word_ready && i_word_valid;
   wire        first = taken && !sec_r;
   wire        dbl_op = i_word[15:12] == OP4_MOVE_FF || i_word[15:10] == 6'h3B;

   // Phase follows enabled edges only, so a frozen clock enable is harmless
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) ph_r <= 2'h0;
      else if (i_clk_en) ph_r <= ph_r + 2'h1;
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) sec_r <= 1'b0;
      else if (taken) sec_r <= !sec_r && dbl_op;
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_arst_n);

   chk_cycle_start: assert property (o_cycle_start == (ph_r == 2'h0))
      else $error("cycle start off phase zero");
   chk_ready_phase: assert property (o_word_ready |-> ph_r == 2'h3)
      else $error("word taken outside last phase");
   chk_single_valid: assert property (first && !dbl_op |=> o_dec_valid)
      else $error("single word not decoded");
   chk_first_quiet: assert property (first && dbl_op |=> !o_dec_valid)
      else $error("first of two words decoded alone");
   chk_double_cost: assert property (taken && sec_r |=>
      o_dec_valid && o_double_word && o_cycle_cost == CYC_TWO)
      else $error("double word cost wrong");
   chk_lone_nop: assert property (first && i_word[15:12] == SECOND_WORD_TAG |=>
      o_exec_nop && o_cycle_cost == CYC_ONE)
      else $error("lone second word not a nop");
   chk_byte_fields: assert property (first && i_word[15:12] inside {[4'h1:4'h5]} |=>
      o_class == IWD_CLS_BYTE && o_dest_is_file == $past(i_word[9])
      && o_use_bank_select == $past(i_word[8])
      && o_file_addr == $past(i_word[7:0]))
      else $error("byte operand fields wrong");
   chk_bit_fields: assert property (first && i_word[15:12] inside {[4'h7:4'hB]} |=>
      o_class == IWD_CLS_BIT && o_bit_index == $past(i_word[11:9]))
      else $error("bit operand fields wrong");
   chk_rel_branch: assert property (first && i_word[15:12] == OP4_BRANCH_REL |=>
      o_branch_rel && o_cycle_cost == CYC_TWO)
      else $error("relative branch wrong");
   chk_filler_gap: assert property ($rose(o_dec_valid) && !o_double_word
      && o_cycle_cost == CYC_TWO |-> !o_word_ready [*4])
      else $error("no filler cycle after costly word");

   cover property (taken && sec_r);
   cover property ($rose(o_dec_valid) && o_cycle_cost == CYC_TWO && !o_double_word);
   cover property (first && i_word[15:12] == SECOND_WORD_TAG);
endmodule : iwd_decoder_asserts

bind iwd_decoder iwd_decoder_asserts i_chk (.i_sys_clk, .i_arst_n, .i_clk_en, .i_word_valid,
   .i_word, .o_word_ready, .o_cycle_start, .o_dec_valid, .o_class, .o_double_word,
   .o_exec_nop, .o_dest_is_file, .o_use_bank_select, .o_file_addr, .o_bit_index,
   .o_branch_rel, .o_cycle_cost);
`default_nettype wire

// *** dv/instruction_word_decoder_bench.sv ***
// Testbench: random and corner-case instruction words through the decoder
`timescale 1ns/100ps
`default_nettype none
module instruction_word_decoder_bench;
   import iwd_pkg::*;
   logic i_sys_clk = 1'b0, i_arst_n = 1'b0, i_clk_en = 1'b1, stall = 1'b0, rnd_on = 1'b0;
   logic i_word_valid, i_cond_true, o_word_ready, o_cycle_start, o_dec_valid, o_double_word;
   logic o_exec_nop, o_dest_is_file, o_use_bank_select, o_branch_rel, o_branch_cond;
   logic o_fast_mode;
   logic [15:0] i_word;
   logic [7:0]  o_file_addr, o_literal8;
   logic [2:0]  o_bit_index;
   logic [11:0] o_source_file_address, o_target_file_address, o_literal12;
   logic [19:0] o_literal20, o_branch_offset;
   logic [1:0]  o_cycle_cost;
   iwd_class_e    o_class;
   iwd_tbl_mode_e o_table_pointer_update_mode;
   logic [31:0] lfsr = 32'h1279;
   int          fails = 0, num_checks = 0;

   iwd_decoder i_iwd_decoder (.i_sys_clk, .i_arst_n, .i_clk_en, .i_word_valid, .i_word,
      .i_cond_true, .o_word_ready, .o_cycle_start, .o_dec_valid, .o_class, .o_double_word,
      .o_exec_nop, .o_dest_is_file, .o_use_bank_select, .o_file_addr, .o_bit_index,
      .o_source_file_address, .o_target_file_address, .o_literal8, .o_literal12,
      .o_literal20, .o_branch_offset, .o_branch_rel, .o_branch_cond, .o_fast_mode,
      .o_table_pointer_update_mode, .o_cycle_cost);
   iwd_fetch_model i_iwd_fetch_model (.i_sys_clk, .i_clk_en, .i_word_ready(o_word_ready),
      .i_stall(stall), .o_word_valid(i_word_valid), .o_word(i_word),
      .o_cond_true(i_cond_true));

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt

   // Kinds: 0 byte, 1 bit, 2 literal, 3 long branch, 4 short branch,
   // 5 call/goto, 6 move, 7 pointer load, 8 return, 9 table, 10 lone second word
   function automatic logic [31:0] exp_key(input int k, input logic [15:0] a, b);
      case (k)
         0: return {22'h0, a[9:0]};
         1: return {20'h0, a[11:0]};
         2: return {24'h0, a[7:0]};
         3: return {12'h0, {9{a[10]}}, a[10:0]};
         4: return {12'h0, {12{a[7]}}, a[7:0]};
         5: return {12'h0, b[11:0], a[7:0]};
         6: return {8'h0, a[11:0], b[11:0]};
         7: return {20'h0, a[7:4], b[7:0]};
         8: return {31'h0, a[0]};
         9: return {30'h0, a[1:0]};
         default: return 32'h1;
      endcase
   endfunction : exp_key

   function automatic logic [31:0] obs(input int k);
      case (k)
         0: return {22'h0, o_dest_is_file, o_use_bank_select, o_file_addr};
         1: return {20'h0, o_bit_index, o_use_bank_select, o_file_addr};
         2: return {24'h0, o_literal8};
         3, 4: return {12'h0, o_branch_offset};
         5: return {12'h0, o_literal20};
         6: return {8'h0, o_source_file_address, o_target_file_address};
         7: return {20'h0, o_literal12};
         8: return {31'h0, o_fast_mode};
         9: return {30'h0, o_table_pointer_update_mode};
         default: return {31'h0, o_exec_nop};
      endcase
   endfunction : obs

   task automatic conclude;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude

   task automatic check(input logic ok, input string m);
      num_checks++;
      if (ok !== 1'b1) begin
         fails++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask : check

   // A cost of zero skips the cost compare
   task automatic run(input int k, input logic [15:0] a, b, input logic c,
                      input logic [1:0] cost);
      int n;
      i_iwd_fetch_model.push(a, c);
      if (k inside {[5:7]}) i_iwd_fetch_model.push(b, 1'b0);
      for (n = 0; n < 400 && o_dec_valid !== 1'b1; n++) @(negedge i_sys_clk);
      if (n >= 400) begin
         fails++;
         conclude();
      end
      check(obs(k) === exp_key(k, a, b), "operand field");
      check(k > 9 || o_class === (k < 3 ? iwd_class_e'(k) :
         (k == 7 ? IWD_CLS_LITERAL : IWD_CLS_CONTROL)), "class");
      check(k != 4 || o_branch_cond === 1'b1, "branch condition");
      check(k > 9 || o_double_word === (k inside {[5:7]}), "word count");
      check(cost === 2'h0 || o_cycle_cost === cost, "cycle cost");
      for (n = 0; n < 400 && o_dec_valid === 1'b1; n++) @(negedge i_sys_clk);
   endtask : run

   always #10 i_sys_clk = ~i_sys_clk;

   // Random clock-enable gaps and fetch stalls only while rnd_on is set
   always @(posedge i_sys_clk) begin
      lfsr <= nxt(lfsr);
      i_clk_en <= !rnd_on || lfsr[2:0] != 3'h0;
      stall <= rnd_on && lfsr[5:4] == 2'h0;
   end

   initial begin
      logic [31:0] r;
      logic [5:0]  bop[4] = '{6'h09, 6'h05, 6'h04, 6'h14};
      repeat (10) @(posedge i_sys_clk);
      i_arst_n <= 1'b1;
      run(3, 16'hD400, 16'h0000, 1'b0, CYC_TWO);
      run(4, 16'hE280, 16'h0000, 1'b1, CYC_TWO);
      run(4, 16'hE27F, 16'h0000, 1'b0, CYC_ONE);
      run(5, 16'hEF12, 16'hF345, 1'b0, CYC_TWO);
      run(5, 16'hED00, 16'hFFFF, 1'b0, CYC_TWO);
      run(6, 16'hC000, 16'hFFFF, 1'b0, CYC_TWO);
      run(6, 16'hCFFF, 16'hF000, 1'b0, CYC_TWO);
      run(7, 16'hEE1A, 16'hF0C3, 1'b0, CYC_TWO);
      run(10, 16'hF123, 16'h0000, 1'b0, CYC_ONE);
      run(0, 16'h2FFF, 16'h0000, 1'b1, CYC_TWO);
      for (int m = 0; m < 2; m++) run(8, 16'h0012 | m, 16'h0, 1'b0, CYC_TWO);
      for (int m = 0; m < 8; m++) run(9, 16'h0008 + m, 16'h0, 1'b0, 2'h0);
      rnd_on = 1'b1;
      for (int i = 0; i < 80; i++) begin
         r = lfsr;
         case (i % 4)
            0: run(0, {bop[r[14:13]], r[9:0]}, 16'h0, 1'b0, CYC_ONE);
            1: run(1, {4'h8, r[11:0]}, 16'h0, 1'b0, CYC_ONE);
            2: run(1, {4'hB, r[11:0]}, 16'h0, r[12], r[12] ? CYC_TWO : CYC_ONE);
            default: run(2, {5'h01, r[10:0]}, 16'h0, 1'b0,
               r[10:8] == 3'h4 ? CYC_TWO : CYC_ONE);
         endcase
      end
      conclude();
   end
endmodule : instruction_word_decoder_bench
`default_nettype wire
